//--- hw/led_fault_supervisor_regs.vh
// register map, field positions, reset values and timing counts of the led fault supervisor
// Overview of operation
// RULE_01: die over shutdown threshold stops boost and sinks
// RULE_02: restart only after cooling below restart level; code needs cool_s to leave ST_THERM, not to enter ST_RUN from other states
// RULE_03: one writable bit enables thermal current derating
// RULE_04: derating starts within margin below shutdown
// RULE_05: derating enable resets to off
// RULE_06: first enable runs pin check before soft start
// RULE_07: pin below short level counts as grounded
// RULE_08: pin above in-use level counts as used
// RULE_09: pin between both levels counts as unused
// RULE_10: host may disable channels one by one
// RULE_11: unused or disabled channels leave regulation and feedback
// RULE_12: grounded pin at check holds soft start
// RULE_13: enabled channel below target requests more voltage
// RULE_14: overvoltage trip retests unregulated enabled channels
// RULE_15: grounded retested channel latches boost fully off
// RULE_16: grounded shutdown raises fault eleven and short bit
// RULE_17: open retested channel dropped, others keep running
// RULE_18: dropping open channel clears the fault pin
// RULE_19: dropped channel sets its latched unregulated bit
// RULE_20: latched bit zero when regulating, one on trip
// RULE_21: channel reporting tied to overvoltage fault eight
// RULE_22: startup failure to regulate handled as open pin
// RULE_23: input overcurrent latches off until enable toggles
`ifndef LED_FAULT_SUPERVISOR_REGS_VH
`define LED_FAULT_SUPERVISOR_REGS_VH

`define LFS_ADDR_UNREG_LO 8'h3a
`define LFS_ADDR_UNREG_HI 8'h3b
`define LFS_ADDR_DIS_LO 8'h40
`define LFS_ADDR_DIS_HI 8'h41
`define LFS_ADDR_CFG 8'h42
`define LFS_ADDR_FAULT 8'h43
`define LFS_ADDR_SHORT_LO 8'h44
`define LFS_ADDR_SHORT_HI 8'h45
`define LFS_ADDR_UNUSED_LO 8'h46
`define LFS_ADDR_UNUSED_HI 8'h47

`define LFS_CFG_DERATE_BIT 0
`define LFS_CFG_RESET 8'h00
`define LFS_DIS_RESET 16'h0000

`define LFS_FLT_OCP_BIT 0
`define LFS_FLT_THERM_BIT 1
`define LFS_FLT_OV_BIT 2
`define LFS_FLT_PINSHORT_BIT 3

`define LFS_CLK_NS 25
`define LFS_CHECK_NS 10000
`define LFS_CHECK_CYC ((`LFS_CHECK_NS + `LFS_CLK_NS - 1) / `LFS_CLK_NS)

`endif

//--- hw/led_fault_supervisor.v
// fault supervision for a sixteen channel boost led driver
`timescale 1ns/10ps
`include "led_fault_supervisor_regs.vh"

module led_fault_supervisor (
   input wire mclk_i,
   input wire rst_n_i,
   input wire en_i,
   input wire thermal_hot_i,
   input wire thermal_cool_i,
   input wire derate_zone_i,
   input wire overvolt_trip_i,
   input wire in_ocp_i,
   input wire [15:0] pin_short_i,
   input wire [15:0] pin_inuse_i,
   input wire [15:0] in_reg_i,
   input wire [7:0] reg_addr_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [7:0] reg_wdata_i,
   output reg [7:0] reg_rdata_o,
   output reg boost_en_o,
   output reg [15:0] sink_en_o,
   output reg [15:0] fb_request_o,
   output reg input_switch_on_o,
   output reg soft_start_go_o,
   output reg derate_o,
   output reg fault_n_o,
   output reg check_busy_o
);

   localparam [7:0] ST_IDLE = 8'h01;
   localparam [7:0] ST_CHECK = 8'h02;
   localparam [7:0] ST_HOLD = 8'h04;
   localparam [7:0] ST_RUN = 8'h08;
   localparam [7:0] ST_RETEST = 8'h10;
   localparam [7:0] ST_SHORTOFF = 8'h20;
   localparam [7:0] ST_OCP = 8'h40;
   localparam [7:0] ST_THERM = 8'h80;
   localparam [31:0] CHECK_FULL = `LFS_CHECK_CYC;
   localparam [8:0] CHECK_CYC = CHECK_FULL[8:0];

   function [7:0] byte_sel;
      input [15:0] v;
      input hi;
      begin
         byte_sel = hi ? v[15:8] : v[7:0];
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // input synchronisers

   wire [53:0] raw_in;
   reg [53:0] sync1;
   reg [53:0] sync2;

   assign raw_in = {en_i, thermal_hot_i, thermal_cool_i, derate_zone_i, overvolt_trip_i, in_ocp_i,
                    pin_short_i, pin_inuse_i, in_reg_i};

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1 <= 54'h0;
         sync2 <= 54'h0;
      end else begin
         sync1 <= raw_in;
         sync2 <= sync1;
      end
   end

   wire en_s = sync2[53];
   wire hot_s = sync2[52];
   wire cool_s = sync2[51];
   wire zone_s = sync2[50];
   wire ov_s = sync2[49];
   wire ocp_s = sync2[48];
   wire [15:0] short_s = sync2[47:32];
   wire [15:0] inuse_s = sync2[31:16];
   wire [15:0] inreg_s = sync2[15:0];

   ////////////////////////////////////////////////////////////////////////
   // state

   reg [7:0] state;
   reg [7:0] next_state;
   reg [8:0] chk_cnt;
   reg first_done;
   reg [15:0] unused;
   reg [15:0] removed;
   reg [15:0] unreg_latch;
   reg [15:0] short_latch;
   reg [15:0] dis;
   reg [7:0] cfg;
   reg ov_flag;
   reg thermal_flag;
   reg ocp_flag;
   reg pinshort_flag;

   wire [15:0] active = ~unused & ~dis & ~removed; // see RULE_11
   wire [15:0] suspects = active & ~inreg_s; // see RULE_14
   wire suspect_short = |(suspects & short_s);
   wire running = (state == ST_RUN) || (state == ST_RETEST);
   wire power_on = running && !hot_s; // see RULE_01

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (en_s) begin
               if (!first_done) begin
                  next_state = ST_CHECK; // see RULE_06
               end else begin
                  next_state = ST_RUN;
               end
            end
         end
         ST_CHECK: begin
            if (chk_cnt == CHECK_CYC) begin
               if (|short_s) begin
                  next_state = ST_HOLD; // see RULE_12
               end else begin
                  next_state = ST_RUN;
               end
            end
         end
         ST_HOLD: begin
            if (!(|short_s)) begin
               next_state = ST_RUN; // see RULE_12
            end
         end
         ST_RUN: begin
            if (hot_s) begin
               next_state = ST_THERM; // see RULE_01
            end else if (ov_s) begin
               next_state = ST_RETEST; // see RULE_14
            end
         end
         ST_RETEST: begin
            if (suspect_short) begin
               next_state = ST_SHORTOFF; // see RULE_15
            end else begin
               next_state = ST_RUN; // see RULE_17
            end
         end
         ST_THERM: begin
            if (cool_s && !hot_s) begin
               next_state = ST_RUN; // see RULE_02
            end
         end
         ST_SHORTOFF: begin
            next_state = ST_SHORTOFF;
         end
         ST_OCP: begin
            next_state = ST_OCP; // see RULE_23
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      if (state != ST_OCP && ocp_s) begin
         next_state = ST_OCP; // see RULE_23
      end
      if (!en_s) begin
         next_state = ST_IDLE; // see RULE_23
      end
   end

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_IDLE;
         chk_cnt <= 9'h000;
         first_done <= 1'b0;
         unused <= 16'h0000;
      end else begin
         state <= next_state;
         if (state == ST_CHECK) begin
            chk_cnt <= chk_cnt + 9'h001;
         end else begin
            chk_cnt <= 9'h000;
         end
         if (state == ST_CHECK && chk_cnt == CHECK_CYC) begin
            first_done <= 1'b1;
            unused <= ~short_s & ~inuse_s; // see RULE_07 see RULE_08 see RULE_09
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // fault latches, cleared while enable is low; the thermal flag also clears on cool

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         removed <= 16'h0000;
         unreg_latch <= 16'h0000;
         short_latch <= 16'h0000;
         ov_flag <= 1'b0;
         thermal_flag <= 1'b0;
         ocp_flag <= 1'b0;
         pinshort_flag <= 1'b0;
      end else if (!en_s) begin
         removed <= 16'h0000;
         unreg_latch <= 16'h0000;
         short_latch <= 16'h0000;
         ov_flag <= 1'b0;
         thermal_flag <= 1'b0;
         ocp_flag <= 1'b0;
         pinshort_flag <= 1'b0;
      end else begin
         if (state == ST_RUN && ov_s) begin
            ov_flag <= 1'b1; // see RULE_21
         end
         if (state == ST_RETEST) begin
            if (suspect_short) begin
               short_latch <= short_latch | (suspects & short_s); // see RULE_16
               pinshort_flag <= 1'b1; // see RULE_16
            end else begin
               removed <= removed | suspects; // see RULE_17 see RULE_22
               unreg_latch <= unreg_latch | suspects; // see RULE_19 see RULE_20
               ov_flag <= 1'b0; // see RULE_18
            end
         end
         // heat seen in any enabled state latches, so it stays set after a check until cool is seen
         if (hot_s) begin
            thermal_flag <= 1'b1;
         end else if (cool_s) begin
            thermal_flag <= 1'b0; // see RULE_02
         end
         if (ocp_s) begin
            ocp_flag <= 1'b1; // see RULE_23
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register port

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dis <= `LFS_DIS_RESET;
         cfg <= `LFS_CFG_RESET; // see RULE_05
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            `LFS_ADDR_DIS_LO: begin
               dis[7:0] <= reg_wdata_i; // see RULE_10
            end
            `LFS_ADDR_DIS_HI: begin
               dis[15:8] <= reg_wdata_i; // see RULE_10
            end
            `LFS_ADDR_CFG: begin
               cfg <= {7'h00, reg_wdata_i[`LFS_CFG_DERATE_BIT]}; // see RULE_03
            end
            default: begin
               cfg <= cfg;
            end
         endcase
      end
   end

   reg [7:0] rd_mux;

   always @* begin
      case (reg_addr_i)
         `LFS_ADDR_UNREG_LO: begin
            rd_mux = byte_sel(unreg_latch, 1'b0); // see RULE_19
         end
         `LFS_ADDR_UNREG_HI: begin
            rd_mux = byte_sel(unreg_latch, 1'b1); // see RULE_19
         end
         `LFS_ADDR_DIS_LO: begin
            rd_mux = byte_sel(dis, 1'b0);
         end
         `LFS_ADDR_DIS_HI: begin
            rd_mux = byte_sel(dis, 1'b1);
         end
         `LFS_ADDR_CFG: begin
            rd_mux = cfg;
         end
         `LFS_ADDR_FAULT: begin
            rd_mux = {4'h0, pinshort_flag, ov_flag, thermal_flag, ocp_flag}; // see RULE_21
         end
         `LFS_ADDR_SHORT_LO: begin
            rd_mux = byte_sel(short_latch, 1'b0); // see RULE_16
         end
         `LFS_ADDR_SHORT_HI: begin
            rd_mux = byte_sel(short_latch, 1'b1); // see RULE_16
         end
         `LFS_ADDR_UNUSED_LO: begin
            rd_mux = byte_sel(unused, 1'b0);
         end
         `LFS_ADDR_UNUSED_HI: begin
            rd_mux = byte_sel(unused, 1'b1);
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per channel enables

   wire [15:0] next_sink;
   wire [15:0] next_fb;
   genvar ch;

   generate
      for (ch = 0; ch < 16; ch = ch + 1) begin : g_chan
         // a channel drives and requests only while powered and still active
         assign next_sink[ch] = power_on & active[ch]; // see RULE_11
         assign next_fb[ch] = power_on & active[ch] & ~inreg_s[ch]; // see RULE_13
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // power stage controls

   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         boost_en_o <= 1'b0;
         sink_en_o <= 16'h0000;
         fb_request_o <= 16'h0000;
         input_switch_on_o <= 1'b0;
         soft_start_go_o <= 1'b0;
         derate_o <= 1'b0;
         fault_n_o <= 1'b1;
         check_busy_o <= 1'b0;
      end else begin
         // boost and sinks off outside run and retest, incl. thermal and latched states
         boost_en_o <= power_on; // see RULE_01 see RULE_15 see RULE_23
         sink_en_o <= next_sink; // see RULE_01 see RULE_11
         fb_request_o <= next_fb; // see RULE_13
         input_switch_on_o <= en_s && state != ST_OCP && !ocp_s; // see RULE_23
         soft_start_go_o <= running; // see RULE_12
         derate_o <= running && cfg[`LFS_CFG_DERATE_BIT] && zone_s; // see RULE_04
         fault_n_o <= !(ocp_flag || thermal_flag || ov_flag || pinshort_flag); // see RULE_18 see RULE_23
         check_busy_o <= (state == ST_CHECK) || (state == ST_HOLD);
      end
   end

endmodule // led_fault_supervisor

//--- tb/lfs_checker.sv
// port assertions for the led fault supervisor
`timescale 1ns/10ps
module lfs_checker (
   input wire mclk_i,
   input wire rst_n_i,
   input wire en_i,
   input wire thermal_hot_i,
   input wire thermal_cool_i,
   input wire derate_zone_i,
   input wire in_ocp_i,
   input wire [15:0] pin_short_i,
   input wire [15:0] sink_en_o,
   input wire [15:0] fb_request_o,
   input wire boost_en_o,
   input wire input_switch_on_o,
   input wire soft_start_go_o,
   input wire derate_o,
   input wire fault_n_o,
   input wire check_busy_o
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);
   property p_therm_off;
      thermal_hot_i [*5] |-> !boost_en_o && sink_en_o == 16'h0000;
   endproperty
   a_therm_off: assert property (p_therm_off) else $error("power on while hot");
   property p_therm_hyst;
      !boost_en_o && !fault_n_o && input_switch_on_o && !thermal_cool_i |=> !boost_en_o;
   endproperty
   a_therm_hyst: assert property (p_therm_hyst) else $error("restart before cooling");
   property p_derate_off;
      !derate_zone_i [*5] |-> !derate_o;
   endproperty
   a_derate_off: assert property (p_derate_off) else $error("derating outside zone");
   property p_fb_enabled;
      (fb_request_o & ~sink_en_o) == 16'h0000;
   endproperty
   a_fb_enabled: assert property (p_fb_enabled) else $error("request from idle channel");
   property p_check_first;
      soft_start_go_o |-> !check_busy_o;
   endproperty
   a_check_first: assert property (p_check_first) else $error("soft start during check");
   property p_short_hold;
      (check_busy_o && pin_short_i != 16'h0000) [*4] |=> check_busy_o && !soft_start_go_o;
   endproperty
   a_short_hold: assert property (p_short_hold) else $error("soft start with short");
   property p_ocp_off;
      (in_ocp_i && en_i) [*5] |-> !input_switch_on_o && !boost_en_o && !fault_n_o;
   endproperty
   a_ocp_off: assert property (p_ocp_off) else $error("overcurrent not handled");
   property p_ocp_latched;
      !input_switch_on_o && !fault_n_o && en_i |=> !input_switch_on_o;
   endproperty
   a_ocp_latched: assert property (p_ocp_latched) else $error("overcurrent not latched");
   c_fault: cover property ($fell(fault_n_o));
   c_ss: cover property ($rose(soft_start_go_o));
   c_der: cover property ($rose(derate_o));
endmodule // lfs_checker
bind led_fault_supervisor lfs_checker i_lfs_checker (.*);

//--- tb/lfs_host.sv
// host model driving the register port
`timescale 1ns/10ps
module lfs_host (
   input wire mclk_i,
   input wire [7:0] rdata_i,
   output reg [7:0] addr_o,
   output reg wr_o,
   output reg rd_o,
   output reg [7:0] wdata_o
);
   initial begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = 8'h00;
   end
   // channel disables and config come from here
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge mclk_i);
      wr_o <= 1'b0;
   endtask
   task rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge mclk_i);
      rd_o <= 1'b0;
      @(posedge mclk_i);
      #1 d = rdata_i;
   endtask
endmodule // lfs_host

//--- tb/tb_led_fault_supervisor.sv
// testbench for the led fault supervisor
`timescale 1ns/10ps
module tb_led_fault_supervisor;
   logic mclk_i, rst_n_i, en_i, thermal_hot_i, thermal_cool_i, derate_zone_i, overvolt_trip_i, in_ocp_i;
   logic reg_wr_i, reg_rd_i, boost_en_o, input_switch_on_o, soft_start_go_o, derate_o, fault_n_o, check_busy_o;
   logic [15:0] pin_short_i, pin_inuse_i, in_reg_i, sink_en_o, fb_request_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rdat;
   int miscompares = 0, samples_checked = 0, cyc = 0;
   led_fault_supervisor i_led_fault_supervisor (.*);
   lfs_host i_lfs_host (.mclk_i(mclk_i), .rdata_i(reg_rdata_o), .addr_o(reg_addr_i), .wr_o(reg_wr_i),
      .rd_o(reg_rd_i), .wdata_o(reg_wdata_i));
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   task end_of_test;
      if (miscompares == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         miscompares++;
         end_of_test;
      end
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      samples_checked++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   task rchk(input logic [7:0] a, input logic [7:0] e);
      i_lfs_host.rd(a, rdat);
      chk({8'h00, rdat}, {8'h00, e});
   endtask
   task wt(input int n);
      repeat (n) @(posedge mclk_i);
      #1;
   endtask
   task wss(input int n);
      for (int i = 0; i < n && soft_start_go_o !== 1'b1; i++) @(posedge mclk_i);
      #1 chk({15'h0, soft_start_go_o}, 16'h0001);
   endtask
   task en_cycle;
      @(posedge mclk_i);
      en_i <= 1'b0;
      wt(8);
      @(posedge mclk_i);
      en_i <= 1'b1;
   endtask
   task ov_hit;
      @(posedge mclk_i);
      overvolt_trip_i <= 1'b1;
      wt(3);
      @(posedge mclk_i);
      overvolt_trip_i <= 1'b0;
      wt(8);
   endtask
   task t_regs;
      rchk(8'h42, 8'h00);
      rchk(8'h3a, 8'h00);
      rchk(8'h00, 8'h00);
      i_lfs_host.wr(8'h3a, 8'hff);
      rchk(8'h3a, 8'h00);
      i_lfs_host.wr(8'h40, 8'h02);
      rchk(8'h40, 8'h02);
   endtask
   task t_start;
      @(posedge mclk_i);
      en_i <= 1'b1;
      wt(500);
      chk({14'h0, check_busy_o, soft_start_go_o}, 16'h0002);
      @(posedge mclk_i);
      pin_short_i <= 16'h0000;
      pin_inuse_i <= 16'h3fff;
      wss(100);
      wt(10);
      chk(sink_en_o & 16'hc002, 16'h0000);
      chk(fb_request_o & 16'hc022, 16'h0020);
      rchk(8'h47, 8'hc0);
      rchk(8'h46, 8'h00);
   endtask
   task t_open;
      ov_hit;
      chk({14'h0, boost_en_o, fault_n_o}, 16'h0003);
      chk((sink_en_o | fb_request_o) & 16'h0020, 16'h0000);
      rchk(8'h3a, 8'h20);
      rchk(8'h3b, 8'h00);
   endtask
   task t_therm;
      @(posedge mclk_i);
      thermal_hot_i <= 1'b1;
      thermal_cool_i <= 1'b0;
      wt(8);
      chk({14'h0, boost_en_o, fault_n_o}, 16'h0000);
      rchk(8'h43, 8'h02);
      @(posedge mclk_i);
      thermal_hot_i <= 1'b0;
      wt(8);
      chk({15'h0, boost_en_o}, 16'h0000);
      @(posedge mclk_i);
      thermal_cool_i <= 1'b1;
      wt(8);
      @(posedge mclk_i);
      thermal_cool_i <= 1'b0;
      derate_zone_i <= 1'b1;
      wt(8);
      chk({14'h0, boost_en_o, derate_o}, 16'h0002);
      i_lfs_host.wr(8'h42, 8'h01);
      wt(6);
      chk({15'h0, derate_o}, 16'h0001);
      i_lfs_host.wr(8'h42, 8'h00);
      wt(6);
      chk({15'h0, derate_o}, 16'h0000);
      @(posedge mclk_i);
      thermal_cool_i <= 1'b1;
      derate_zone_i <= 1'b0;
   endtask
   task t_short;
      @(posedge mclk_i);
      pin_short_i <= 16'h0080;
      in_reg_i <= 16'hff5f;
      ov_hit;
      rchk(8'h44, 8'h80);
      i_lfs_host.rd(8'h43, rdat);
      chk({8'h00, rdat & 8'h08}, 16'h0008);
      chk({8'h00, rdat & 8'h04}, 16'h0004);
      @(posedge mclk_i);
      pin_short_i <= 16'h0000;
      in_reg_i <= 16'hffff;
      wt(20);
      chk({15'h0, boost_en_o}, 16'h0000);
   endtask
   task t_ocp;
      en_cycle;
      wss(20);
      @(posedge mclk_i);
      in_ocp_i <= 1'b1;
      wt(8);
      @(posedge mclk_i);
      in_ocp_i <= 1'b0;
      wt(8);
      chk({13'h0, input_switch_on_o, boost_en_o, fault_n_o}, 16'h0000);
      rchk(8'h43, 8'h01);
      en_cycle;
      wss(20);
      chk({15'h0, input_switch_on_o}, 16'h0001);
   endtask
   initial begin
      rst_n_i = 1'b0;
      en_i = 1'b0;
      thermal_hot_i = 1'b0;
      thermal_cool_i = 1'b1;
      derate_zone_i = 1'b0;
      overvolt_trip_i = 1'b0;
      in_ocp_i = 1'b0;
      pin_short_i = 16'h0008;
      pin_inuse_i = 16'h3ff7;
      in_reg_i = 16'hffdf;
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      t_regs;
      t_start;
      t_open;
      t_therm;
      t_short;
      t_ocp;
      end_of_test;
   end
endmodule // tb_led_fault_supervisor
